// ===== verilog/sbyc_pkg.sv
package sbyc_pkg;

	// ==========================================================
	// Signal polarities
	localparam logic REQ_ASSERTED    = 1'h0;
	localparam logic PERMIT_ASSERTED = 1'h1;

	// ==========================================================
	// Timing counts
	localparam int unsigned HOUSEKEEP_CYCLES = 4;
	localparam logic [2:0]  HOUSEKEEP_LAST   = 3'(HOUSEKEEP_CYCLES - 1);

	// ==========================================================
	// Reset values
	localparam logic        RST_SUPPLY_OK = 1'h0;
	localparam logic [2:0]  RST_COUNT     = 3'h0;

	// ==========================================================
	// Sequencer states
	typedef enum logic [1:0] {
		SBYC_RUN,
		SBYC_HOUSEKEEP,
		SBYC_STANDBY
	} sbyc_state_e;

endpackage

// ===== verilog/sbyc_io_if.sv
`timescale 1ns/100ps
// ==========================================================
// Output gating signals between sequencer and I/O gate
interface sbyc_io_if;
	logic       supply_ok;
	logic [7:0] out_data;
	logic [7:0] pad_out;
	logic [7:0] pad_oe_n;

	modport seq
	(
		output supply_ok,
		output out_data,
		input  pad_out,
		input  pad_oe_n
	);
	modport gate
	(
		input  supply_ok,
		input  out_data,
		output pad_out,
		output pad_oe_n
	);
endinterface

// ===== verilog/sbyc_io_gate.sv
`timescale 1ns/100ps
// ==========================================================
// Per-pin tristate gate
module sbyc_io_gate
(
	sbyc_io_if.gate io
);
	// One gate per user output
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_pin
			assign io.pad_out[g]  = io.supply_ok & io.out_data[g];
			assign io.pad_oe_n[g] = ~io.supply_ok;
		end
	endgenerate
endmodule

// ===== verilog/sbyc_top.sv
`timescale 1ns/100ps
module sbyc_top
(
	input  wire logic       CLK_I,
	input  wire logic       RSTN_I,
	input  wire logic       STANDBY_REQUEST_PIN_N_I,
	input  wire logic       STANDBY_PERMIT_I,
	input  wire logic       CORE_SUPPLY_OK_I,
	input  wire logic       IO_SUPPLY_OK_I,
	input  wire logic [7:0] USER_OUT_I,
	output logic            STANDBY_ENTERED_O,
	output logic            CLOCK_GATE_O,
	output logic [7:0]      PAD_OUT_O,
	output logic [7:0]      PAD_OE_N_O
);

	// ==========================================================
	// Reset release synchroniser
	logic rst_meta_ff;
	logic rst_sync_n_ff;
	logic rst_n;

	// Asserts at once, lifts on the second edge after the pin is released
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			rst_meta_ff   <= 1'h0;
			rst_sync_n_ff <= 1'h0;
		end
		else
		begin
			rst_meta_ff   <= 1'h1;
			rst_sync_n_ff <= rst_meta_ff;
		end
	end

	// Internal reset for the rest of the block
	assign rst_n = rst_sync_n_ff;

	// ==========================================================
	// State record
	typedef struct packed {
		logic                      req_meta;
		logic                      req_n;
		logic                      core_meta;
		logic                      core_ok;
		logic                      io_meta;
		logic                      io_ok;
		logic [2:0]                count;
		sbyc_pkg::sbyc_state_e     state;
		logic                      entered;
		logic                      clk_gate;
	} sbyc_state_s;

	sbyc_state_s cur_ff;
	sbyc_state_s nxt_cur;

	// Entry condition; permit is consulted nowhere else
	function automatic logic entry_ok(input logic req_n, input logic permit);
		entry_ok = (req_n == sbyc_pkg::REQ_ASSERTED) &&
			(permit == sbyc_pkg::PERMIT_ASSERTED);
	endfunction

	// ==========================================================
	// Next state
	always_comb
	begin
		nxt_cur           = cur_ff;
		nxt_cur.req_meta  = STANDBY_REQUEST_PIN_N_I;
		nxt_cur.req_n     = cur_ff.req_meta;
		nxt_cur.core_meta = CORE_SUPPLY_OK_I;
		nxt_cur.core_ok   = cur_ff.core_meta;
		nxt_cur.io_meta   = IO_SUPPLY_OK_I;
		nxt_cur.io_ok     = cur_ff.io_meta;
		unique case (cur_ff.state)
			sbyc_pkg::SBYC_RUN:
			begin
				nxt_cur.entered  = 1'h0;
				nxt_cur.clk_gate = 1'h0;
				nxt_cur.count    = sbyc_pkg::RST_COUNT;
				if (entry_ok(cur_ff.req_n, STANDBY_PERMIT_I))
					nxt_cur.state = sbyc_pkg::SBYC_HOUSEKEEP;
			end
			sbyc_pkg::SBYC_HOUSEKEEP:
			begin
				if (cur_ff.req_n != sbyc_pkg::REQ_ASSERTED)
					nxt_cur.state = sbyc_pkg::SBYC_RUN;
				else if (cur_ff.count == sbyc_pkg::HOUSEKEEP_LAST)
				begin
					nxt_cur.clk_gate = 1'h1;
					nxt_cur.entered  = 1'h1;
					nxt_cur.state    = sbyc_pkg::SBYC_STANDBY;
				end
				else
					nxt_cur.count = cur_ff.count + 3'h1;
			end
			sbyc_pkg::SBYC_STANDBY:
			begin
				if (cur_ff.req_n != sbyc_pkg::REQ_ASSERTED)
				begin
					nxt_cur.entered  = 1'h0;
					nxt_cur.clk_gate = 1'h0;
					nxt_cur.state    = sbyc_pkg::SBYC_RUN;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur_ff           <= '0;
			cur_ff.req_meta  <= 1'h1;
			cur_ff.req_n     <= 1'h1;
			cur_ff.core_meta <= sbyc_pkg::RST_SUPPLY_OK;
			cur_ff.core_ok   <= sbyc_pkg::RST_SUPPLY_OK;
			cur_ff.io_meta   <= sbyc_pkg::RST_SUPPLY_OK;
			cur_ff.io_ok     <= sbyc_pkg::RST_SUPPLY_OK;
			cur_ff.state     <= sbyc_pkg::SBYC_RUN;
		end
		else
			cur_ff <= nxt_cur;
	end

	// ==========================================================
	// Output data register and tristate gate
	sbyc_io_if io ();
	logic [7:0] out_data_ff;

	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
			out_data_ff <= 8'h00;
		else
			out_data_ff <= USER_OUT_I;
	end

	assign io.supply_ok = cur_ff.core_ok & cur_ff.io_ok;
	assign io.out_data  = out_data_ff;

	sbyc_io_gate u_gate
	(
		.io (io.gate)
	);

	// Top outputs
	assign PAD_OUT_O         = io.pad_out;
	assign PAD_OE_N_O        = io.pad_oe_n;
	assign STANDBY_ENTERED_O = cur_ff.entered;
	assign CLOCK_GATE_O      = cur_ff.clk_gate;

	// ==========================================================
	// Checks
	// Sequencer entry, abort and exit
	a_no_entry_alone: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(cur_ff.state == sbyc_pkg::SBYC_RUN && !STANDBY_PERMIT_I) |=>
		cur_ff.state != sbyc_pkg::SBYC_HOUSEKEEP)
		else $error("standby left run without permit");
	a_entry_start: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(cur_ff.state == sbyc_pkg::SBYC_RUN && !cur_ff.req_n && STANDBY_PERMIT_I) |=>
		cur_ff.state == sbyc_pkg::SBYC_HOUSEKEEP)
		else $error("entry not started");
	a_exit_on_release: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(cur_ff.entered && cur_ff.req_n) |=> !STANDBY_ENTERED_O)
		else $error("standby not left on release");
	a_abort_release: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(cur_ff.state == sbyc_pkg::SBYC_HOUSEKEEP && cur_ff.req_n) |=>
		(cur_ff.state == sbyc_pkg::SBYC_RUN && !STANDBY_ENTERED_O))
		else $error("housekeeping not aborted on release");
	a_entered_delay: assert property (@(posedge CLK_I) disable iff (!rst_n)
		$rose(STANDBY_ENTERED_O) |-> $past(cur_ff.state, 2) == sbyc_pkg::SBYC_HOUSEKEEP
		&& CLOCK_GATE_O)
		else $error("entered flag early");
	a_entry_on_count: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(cur_ff.state == sbyc_pkg::SBYC_HOUSEKEEP && !cur_ff.req_n &&
		cur_ff.count == sbyc_pkg::HOUSEKEEP_LAST) |=> (STANDBY_ENTERED_O && CLOCK_GATE_O))
		else $error("entered flag missing after housekeeping");
	a_run_quiet: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(cur_ff.state == sbyc_pkg::SBYC_RUN) |->
		(!STANDBY_ENTERED_O && !CLOCK_GATE_O))
		else $error("entered flag raised while running");
	a_permit_only_gate: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(cur_ff.state == sbyc_pkg::SBYC_STANDBY && !cur_ff.req_n) |=>
		cur_ff.state == sbyc_pkg::SBYC_STANDBY)
		else $error("permit affected standby");
	a_housekeep_hold: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(cur_ff.state == sbyc_pkg::SBYC_HOUSEKEEP && !cur_ff.req_n &&
		cur_ff.count != sbyc_pkg::HOUSEKEEP_LAST) |=> cur_ff.state == sbyc_pkg::SBYC_HOUSEKEEP)
		else $error("permit affected housekeeping");
	// Pad gating around supply ramps
	a_tristate_down: assert property (@(posedge CLK_I) disable iff (!rst_n)
		!(cur_ff.core_ok && cur_ff.io_ok) |-> PAD_OE_N_O == 8'hff)
		else $error("pins driven without supply");
	a_drive_up: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(cur_ff.core_ok && cur_ff.io_ok) |-> PAD_OE_N_O == 8'h00 &&
		PAD_OUT_O == out_data_ff)
		else $error("pins not driving buffer input");
	a_supply_sync: assert property (@(posedge CLK_I) disable iff (!rst_n)
		($fell(cur_ff.core_ok) || $fell(cur_ff.io_ok)) |-> PAD_OE_N_O == 8'hff)
		else $error("tristate late");

	// Scenario covers

	c_enter: cover property (@(posedge CLK_I) disable iff (!rst_n) $rose(STANDBY_ENTERED_O));
	c_exit: cover property (@(posedge CLK_I) disable iff (!rst_n) $fell(STANDBY_ENTERED_O));
	c_abort: cover property (@(posedge CLK_I) disable iff (!rst_n)
		cur_ff.state == sbyc_pkg::SBYC_HOUSEKEEP && cur_ff.req_n);
	c_power: cover property (@(posedge CLK_I) disable iff (!rst_n) $fell(PAD_OE_N_O[0]));

endmodule

// ===== test/sbyc_partner.sv
`timescale 1ns/100ps
// ==========================================================
// Fabric control logic that drives the request pin and the permit
module sbyc_partner
(
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic req_i,
	input  wire logic allow_i,
	output logic      pin_n_o,
	output logic      permit_o
);
	logic allow_ff;
	// Registered pin and permit; permit rises only while the pin is idle, and also clears when a held request is released
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pin_n_o  <= 1'h1;
			permit_o <= 1'h0;
			allow_ff <= 1'h0;
		end
		else
		begin
			allow_ff <= allow_i;
			pin_n_o  <= ~req_i;
			if (!pin_n_o && !req_i)
				permit_o <= 1'h0;
			else if (pin_n_o && allow_i && !allow_ff)
				permit_o <= 1'h1;
			else if (pin_n_o && !allow_i)
				permit_o <= 1'h0;
		end
	end
endmodule

// ===== test/standby_entry_control_tb.sv
`timescale 1ns/100ps
module standby_entry_control_tb;
	logic        clk = 1'h0, rstn = 1'h0, req = 1'h0, allow = 1'h0, core_ok = 1'h0, io_ok = 1'h0;
	logic [7:0]  dat = 8'h00;
	logic        pin_n, permit, entered, gate;
	logic [7:0]  pad, oe_n;
	logic [31:0] rnd = 32'h0e446092;
	int          fails = 0, n_compared = 0, cyc = 0;
	// ==========================================================
	// Clock and hang guard
	always #10 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			print_verdict();
		end
	end
	sbyc_partner sbyc_partner_inst (.clk_i(clk), .rstn_i(rstn), .req_i(req), .allow_i(allow),
		.pin_n_o(pin_n), .permit_o(permit));
	sbyc_top sbyc_top_inst (.CLK_I(clk), .RSTN_I(rstn), .STANDBY_REQUEST_PIN_N_I(pin_n),
		.STANDBY_PERMIT_I(permit), .CORE_SUPPLY_OK_I(core_ok), .IO_SUPPLY_OK_I(io_ok),
		.USER_OUT_I(dat), .STANDBY_ENTERED_O(entered), .CLOCK_GATE_O(gate),
		.PAD_OUT_O(pad), .PAD_OE_N_O(oe_n));
	// ==========================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic cmp_b(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (exp !== got)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp_f(input string what, input logic exp, input logic got);
		cmp_b(what, {7'h00, exp}, {7'h00, got});
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Edges from request to entered: partner register, two sync stages, take edge, housekeeping
	function automatic int entry_edges();
		return 4 + sbyc_pkg::HOUSEKEEP_CYCLES;
	endfunction
	task automatic print_verdict();
		$display("compared %0d fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		step(6);
		rstn = 1'h1;
		step(3);
		// Supply gating with random data and random permit
		repeat (8)
		begin
			core_ok = 1'h1;
			io_ok = 1'h1;
			rnd = lfsr(rnd);
			dat = rnd[7:0];
			allow = rnd[8];
			step(3);
			cmp_b("oe_n", 8'h00, oe_n);
			cmp_b("pad", dat, pad);
			if (rnd[9]) core_ok = 1'h0;
			else io_ok = 1'h0;
			step(3);
			cmp_b("oe_n", 8'hff, oe_n);
		end
		$display("test gating done");
		core_ok = 1'h1;
		io_ok = 1'h1;
		allow = 1'h0;
		step(3);
		// Request without permit, then permit raised too late
		req = 1'h1;
		step(15);
		cmp_f("entered", 1'h0, entered);
		allow = 1'h1;
		step(15);
		cmp_f("entered", 1'h0, entered);
		// Permit without request, then both
		req = 1'h0;
		allow = 1'h0;
		step(3);
		allow = 1'h1;
		step(15);
		cmp_f("entered", 1'h0, entered);
		req = 1'h1;
		step(entry_edges() - 1);
		cmp_f("entered", 1'h0, entered);
		step(1);
		cmp_f("entered", 1'h1, entered);
		cmp_f("gate", 1'h1, gate);
		cmp_b("pad", dat, pad);
		$display("test entry done");
		// Exit, then request alone must not re-enter
		req = 1'h0;
		step(5);
		cmp_f("entered", 1'h0, entered);
		cmp_f("gate", 1'h0, gate);
		req = 1'h1;
		step(15);
		cmp_f("entered", 1'h0, entered);
		// Request released during housekeeping
		req = 1'h0;
		allow = 1'h0;
		step(3);
		allow = 1'h1;
		step(2);
		req = 1'h1;
		step(3);
		req = 1'h0;
		step(15);
		cmp_f("entered", 1'h0, entered);
		$display("test exit done");
		print_verdict();
	end
endmodule
